// ---- rtl/cyclic_timer.sv ----
// Cyclic timer driving the high-side output for cyclic sense and cyclic wake.
// Assumes settings are stable between restart pulses from the register block.
`timescale 1ns/1ps
module cyclic_timer
  import wake_timer_regs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Settings
  input  wire logic [2:0] i_on_sel,
  input  wire logic [3:0] i_per_sel,
  input  wire logic       i_assigned,
  input  wire logic       i_restart,
  // Results
  output logic            o_hs_out,
  output logic            o_running,
  output logic            o_period_start
);

  logic [15:0] prescale;
  logic [23:0] tick_count;
  logic        tick;
  logic        next_running;

  // Timer only runs once assigned and given a real on-time
  assign next_running = i_assigned && (i_on_sel != ON_OFF_LOW) &&
                        (i_on_sel != ON_OFF_HIGH) && (i_on_sel != ON_RESERVED);
  assign tick = (prescale == 16'(TICK_CYCLES_P - 1));

  // Base tick prescaler, restarted with any new configuration
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prescale <= 16'h0000;
    end else if (i_restart || !next_running || tick) begin
      prescale <= 16'h0000;
    end else begin
      prescale <= prescale + 16'h0001;
    end
  end

  // Position within the period, in ticks
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_count <= 24'h000000;
    end else if (i_restart || !next_running) begin
      tick_count <= 24'h000000;
    end else if (tick) begin
      if (tick_count >= PER_TICKS[i_per_sel] - 24'h000001) begin
        tick_count <= 24'h000000;
      end else begin
        tick_count <= tick_count + 24'h000001;
      end
    end
  end

  // Output high for the on-time at the start of each period
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hs_out       <= 1'b0;
      o_running      <= 1'b0;
      o_period_start <= 1'b0;
    end else begin
      o_running      <= next_running;
      o_period_start <= next_running && !i_restart && (tick_count == 24'h000000) &&
                        (prescale == 16'h0000);
      if (i_on_sel == ON_OFF_HIGH) begin
        o_hs_out <= 1'b1;
      end else if (!next_running) begin
        o_hs_out <= 1'b0;
      end else begin
        o_hs_out <= (tick_count < ON_TICKS[i_on_sel]);
      end
    end
  end

endmodule

// ---- rtl/wake_timer_regs.sv ----
// Serial-reached control registers for wake pulls, bus fast mode and the cyclic timer.
// Assumes serial pins are already synchronous to the system clock.
`timescale 1ns/1ps
module wake_timer_regs
  import wake_timer_regs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_SYS_RST,
  input  wire logic       I_SOFT_RESET,
  // Serial port
  input  wire logic       I_SERIAL_CHIP_SELECT_LOW,
  input  wire logic       I_SERIAL_CLOCK,
  input  wire logic       I_SERIAL_DATA_IN,
  output logic            O_SERIAL_DATA_OUT,
  output logic            O_SERIAL_DATA_OUT_OE,
  // Device mode and configuration from elsewhere
  input  wire logic       I_RESTART_MODE,
  input  wire logic       I_AUX_PIN_IS_WAKE,
  input  wire logic       I_CYCLIC_SENSE_SELECT,
  input  wire logic       I_HS_SWITCH_CLEAR,
  input  wire logic       I_TIMER_ASSIGNED,
  input  wire logic       I_TIMER_WAKE_SOURCE_ENABLE,
  // Pull controls
  output logic            O_WAKE_PIN_PULL_UP,
  output logic            O_WAKE_PIN_PULL_DOWN,
  output logic            O_WAKE_PIN_PULL_AUTO,
  output logic            O_AUX_PIN_PULL_UP,
  output logic            O_AUX_PIN_PULL_DOWN,
  output logic            O_AUX_PIN_PULL_AUTO,
  // Bus transmitter
  output logic            O_SLEW_CONTROL_ENABLE,
  // Cyclic timer results
  output logic            O_HIGH_SIDE_SWITCH_OUTPUT,
  output logic            O_CYCLIC_SENSE_ACTIVE,
  output logic            O_CYCLIC_WAKE_EVENT
);

  spi_state_type state;
  logic          sclk_prev;
  logic          csn_prev;
  logic [4:0]    bit_count;
  logic [15:0]   shift_in;
  logic [7:0]    shift_out;
  logic          sclk_rise;
  logic          sclk_fall;
  logic          csn_rise;
  logic          frame_write;
  logic [6:0]    write_addr;
  logic [7:0]    write_data;
  logic          restart_prev;
  logic          restart_entry;
  logic          timer_clear;
  logic          timer_reload;

  // Register fields
  logic [1:0]    aux_pin_wake_pull_select;
  logic [1:0]    wake_pin_pull_select;
  logic          fast_mode;
  logic [2:0]    timer_on_select;
  logic [3:0]    timer_period_select;

  logic          timer_running;
  logic          period_start;

  // Pull code to {up, down, auto}; used for both pins
  function automatic logic [2:0] pull_decode(input logic [1:0] code);
    logic [2:0] result;
    result = 3'h0;
    unique case (code)
      PULL_NONE: result = 3'h0;
      PULL_DOWN: result = 3'h2;
      PULL_UP:   result = 3'h4;
      PULL_AUTO: result = 3'h1;
    endcase
    return result;
  endfunction

  // Readback image; reserved bits and unmapped addresses give zero
  function automatic logic [7:0] read_image(input logic [6:0] addr);
    logic [7:0] result;
    result = 8'h00;
    if (addr == WAKE_PULL_CONFIG_ADDR) begin
      result[AUX_PULL_LSB +: 2]  = aux_pin_wake_pull_select;
      result[WAKE_PULL_LSB +: 2] = wake_pin_pull_select;
    end else if (addr == BUS_FAST_MODE_CONTROL_ADDR) begin
      result[FAST_MODE_POS] = fast_mode;
    end else if (addr == CYCLIC_TIMER_CONTROL_ADDR) begin
      result[TIMER_ON_LSB +: 3]  = timer_on_select;
      result[TIMER_PERIOD_SELECT_LSB +: 4] = timer_period_select;
    end
    return result;
  endfunction

  // Edge detection on the serial pins and restart mode
  assign sclk_rise     = I_SERIAL_CLOCK && !sclk_prev;
  assign sclk_fall     = !I_SERIAL_CLOCK && sclk_prev;
  assign csn_rise      = I_SERIAL_CHIP_SELECT_LOW && !csn_prev;
  assign restart_entry = I_RESTART_MODE && !restart_prev;

  // Only complete frames commit, and only when select returns high
  assign frame_write = csn_rise && (state == ST_FRAME) && (bit_count == FRAME_COUNT) &&
                       shift_in[WRITE_FLAG_POS];
  assign write_addr  = shift_in[ADDR_MSB:ADDR_LSB];
  assign write_data  = shift_in[7:0];

  // Sense switch cleared in restart wipes the timer to avoid false detection
  assign timer_clear  = I_RESTART_MODE && I_CYCLIC_SENSE_SELECT && I_HS_SWITCH_CLEAR;
  assign timer_reload = timer_clear ||
                        (frame_write && (write_addr == CYCLIC_TIMER_CONTROL_ADDR));

  // Previous pin levels
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      sclk_prev    <= 1'b0;
      csn_prev     <= 1'b1;
      restart_prev <= 1'b0;
    end else begin
      sclk_prev    <= I_SERIAL_CLOCK;
      csn_prev     <= I_SERIAL_CHIP_SELECT_LOW;
      restart_prev <= I_RESTART_MODE;
    end
  end

  // Frame state follows chip select
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (!I_SERIAL_CHIP_SELECT_LOW) begin
            state <= ST_FRAME;
          end
        end
        ST_FRAME: begin
          if (I_SERIAL_CHIP_SELECT_LOW) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Input shifter, sampled on the serial clock rise
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      bit_count <= 5'h00;
      shift_in  <= 16'h0000;
    end else if (state == ST_IDLE) begin
      bit_count <= 5'h00;
    end else if (sclk_rise) begin
      shift_in  <= {shift_in[14:0], I_SERIAL_DATA_IN};
      // Saturate so an overlong frame never aliases to a valid length
      if (bit_count != COUNT_SATURATE) begin
        bit_count <= bit_count + 5'h01;
      end
    end
  end

  // Output shifter: register image loaded once the address byte is in
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      shift_out <= 8'h00;
    end else if (state == ST_IDLE) begin
      shift_out <= 8'h00;
    end else if (sclk_fall) begin
      if (bit_count == READ_LOAD_COUNT) begin
        // First byte is {address, write flag}, so the address sits one bit up
        shift_out <= read_image(shift_in[7:1]);
      end else begin
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end

  assign O_SERIAL_DATA_OUT    = shift_out[7];
  assign O_SERIAL_DATA_OUT_OE = (state == ST_FRAME);

  // Pull register; restart entry leaves both pull fields untouched
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      aux_pin_wake_pull_select <= PULL_RESET;
      wake_pin_pull_select     <= PULL_RESET;
    end else if (I_SOFT_RESET) begin
      aux_pin_wake_pull_select <= PULL_RESET;
      wake_pin_pull_select     <= PULL_RESET;
    end else if (frame_write && (write_addr == WAKE_PULL_CONFIG_ADDR)) begin
      aux_pin_wake_pull_select <= write_data[AUX_PULL_LSB +: 2];
      wake_pin_pull_select     <= write_data[WAKE_PULL_LSB +: 2];
    end else if (restart_entry) begin
      aux_pin_wake_pull_select <= aux_pin_wake_pull_select;
      wake_pin_pull_select     <= wake_pin_pull_select;
    end
  end

  // Bus fast mode; other bits are not stored, so restart keeps only this one
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      fast_mode <= FAST_MODE_RESET;
    end else if (I_SOFT_RESET) begin
      fast_mode <= FAST_MODE_RESET;
    end else if (frame_write && (write_addr == BUS_FAST_MODE_CONTROL_ADDR)) begin
      fast_mode <= write_data[FAST_MODE_POS];
    end else if (restart_entry) begin
      fast_mode <= fast_mode;
    end
  end

  // Timer settings: soft reset and the sense-switch clear wipe them, other failures keep them
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      timer_on_select     <= TIMER_ON_RESET;
      timer_period_select <= TIMER_PERIOD_SELECT_RESET;
    end else if (I_SOFT_RESET || timer_clear) begin
      timer_on_select     <= TIMER_ON_RESET;
      timer_period_select <= TIMER_PERIOD_SELECT_RESET;
    end else if (frame_write && (write_addr == CYCLIC_TIMER_CONTROL_ADDR)) begin
      timer_on_select     <= write_data[TIMER_ON_LSB +: 3];
      timer_period_select <= write_data[TIMER_PERIOD_SELECT_LSB +: 4];
    end else if (restart_entry) begin
      timer_on_select     <= timer_on_select;
      timer_period_select <= timer_period_select;
    end
  end

  // Pull outputs; aux pin pull only while it acts as a wake input
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      {O_WAKE_PIN_PULL_UP, O_WAKE_PIN_PULL_DOWN, O_WAKE_PIN_PULL_AUTO} <= 3'h0;
      {O_AUX_PIN_PULL_UP, O_AUX_PIN_PULL_DOWN, O_AUX_PIN_PULL_AUTO}    <= 3'h0;
    end else begin
      {O_WAKE_PIN_PULL_UP, O_WAKE_PIN_PULL_DOWN, O_WAKE_PIN_PULL_AUTO} <=
        pull_decode(wake_pin_pull_select);
      {O_AUX_PIN_PULL_UP, O_AUX_PIN_PULL_DOWN, O_AUX_PIN_PULL_AUTO} <=
        I_AUX_PIN_IS_WAKE ? pull_decode(aux_pin_wake_pull_select) : 3'h0;
    end
  end

  // Slew control stays on unless fast mode is set
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_SLEW_CONTROL_ENABLE <= 1'b1;
    end else begin
      O_SLEW_CONTROL_ENABLE <= !fast_mode;
    end
  end

  // One timer serves both sense and wake
  cyclic_timer #(
    .TICK_CYCLES_P (TICK_CYCLES_P)
  ) u_cyclic_timer (
    .i_clk          (I_CLK_SYS),
    .i_rst          (I_SYS_RST),
    .i_on_sel       (timer_on_select),
    .i_per_sel      (timer_period_select),
    .i_assigned     (I_TIMER_ASSIGNED),
    .i_restart      (timer_reload),
    .o_hs_out       (O_HIGH_SIDE_SWITCH_OUTPUT),
    .o_running      (timer_running),
    .o_period_start (period_start)
  );

  // Sense and wake may both be active at once
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_CYCLIC_SENSE_ACTIVE <= 1'b0;
      O_CYCLIC_WAKE_EVENT   <= 1'b0;
    end else begin
      O_CYCLIC_SENSE_ACTIVE <= timer_running && I_CYCLIC_SENSE_SELECT;
      O_CYCLIC_WAKE_EVENT   <= period_start && I_TIMER_WAKE_SOURCE_ENABLE;
    end
  end

endmodule

// ---- shared/wake_timer_regs_pkg.sv ----
// Constants and types shared by the wake pull, bus mode and cyclic timer register group.
// Assumes a 50 MHz system clock and a 16-bit serial frame.
package wake_timer_regs_pkg;

  // Serial frame layout: 7-bit address, write flag, 8-bit data
  localparam int unsigned FRAME_BITS            = 16;
  localparam int unsigned ADDR_MSB              = 15;
  localparam int unsigned ADDR_LSB              = 9;
  localparam int unsigned WRITE_FLAG_POS        = 8;
  localparam logic [4:0]  READ_LOAD_COUNT       = 5'h08;
  localparam logic [4:0]  FRAME_COUNT           = 5'h10;
  localparam logic [4:0]  COUNT_SATURATE        = 5'h1F;

  // Register addresses
  localparam logic [6:0]  WAKE_PULL_CONFIG_ADDR      = 7'h08;
  localparam logic [6:0]  BUS_FAST_MODE_CONTROL_ADDR = 7'h0B;
  localparam logic [6:0]  CYCLIC_TIMER_CONTROL_ADDR  = 7'h0C;

  // Field positions
  localparam int unsigned AUX_PULL_LSB          = 6;
  localparam int unsigned WAKE_PULL_LSB         = 0;
  localparam int unsigned FAST_MODE_POS         = 4;
  localparam int unsigned TIMER_ON_LSB          = 4;
  localparam int unsigned TIMER_PERIOD_SELECT_LSB         = 0;

  // Reset values
  localparam logic [1:0]  PULL_RESET            = 2'h0;
  localparam logic        FAST_MODE_RESET       = 1'b0;
  localparam logic [2:0]  TIMER_ON_RESET        = 3'h0;
  localparam logic [3:0]  TIMER_PERIOD_SELECT_RESET       = 4'h0;

  // Pull encodings
  localparam logic [1:0]  PULL_NONE             = 2'h0;
  localparam logic [1:0]  PULL_DOWN             = 2'h1;
  localparam logic [1:0]  PULL_UP               = 2'h2;
  localparam logic [1:0]  PULL_AUTO             = 2'h3;

  // On-time encodings
  localparam logic [2:0]  ON_OFF_LOW            = 3'h0;
  localparam logic [2:0]  ON_OFF_HIGH           = 3'h6;
  localparam logic [2:0]  ON_RESERVED           = 3'h7;

  // Timer base tick, 0.1 ms
  localparam int unsigned CLK_PERIOD_NS         = 20;
  localparam int unsigned TICK_TIME_US          = 100;
  localparam int unsigned TICK_CYCLES           = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;

  // On-times in ticks of 0.1 ms: codes 1..5 are 0.1, 0.3, 1.0, 10, 20 ms
  localparam logic [23:0] ON_TICKS [8] = '{24'h0, 24'h1, 24'h3, 24'hA, 24'h64, 24'hC8, 24'h0, 24'h0};

  // Periods in ticks of 0.1 ms: 10ms .. 1000s
  localparam logic [23:0] PER_TICKS [16] = '{
    24'h000064, 24'h0000C8, 24'h0001F4, 24'h0003E8,
    24'h0007D0, 24'h001388, 24'h002710, 24'h004E20,
    24'h00C350, 24'h0186A0, 24'h030D40, 24'h07A120,
    24'h0F4240, 24'h1E8480, 24'h4C4B40, 24'h989680};

  // Serial slave states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_FRAME = 2'b10
  } spi_state_type;

endpackage

// ---- test/serial_host_model.sv ----
// Host model: serial master issuing 16-bit frames, MSB first.
// Assumes the system clock; pins change only on its falling edge.
`timescale 1ns/1ps
module serial_host_model (
  // System clock
  input  wire logic i_clk,
  // Serial pins
  output logic      o_cs_low,
  output logic      o_sclk,
  output logic      o_mosi,
  input  wire logic i_miso
);
  // Idle levels; the serial clock stands low between frames
  initial begin
    o_cs_low = 1'b1;
    o_sclk   = 1'b0;
    o_mosi   = 1'b0;
  end

  // Frame of nclk clocks, four system clocks per phase for the sampler
  task automatic frame(input logic [6:0] a, input logic w, input logic [7:0] d,
                       input int nclk, output logic [7:0] q);
    logic [15:0] f;
    f = {a, w, d};
    q = 8'h00;
    @(negedge i_clk);
    o_cs_low = 1'b0;
    repeat (2) @(negedge i_clk);
    for (int k = 0; k < nclk; k++) begin
      o_mosi = f[15 - k];
      repeat (4) @(negedge i_clk);
      if (k > 7) q[15 - k] = i_miso; // Read bit settled long after the fall
      o_sclk = 1'b1;
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    repeat (2) @(negedge i_clk);
    o_cs_low = 1'b1;
    o_mosi   = ~o_mosi; // Released line must not keep a stale level
    repeat (2) @(negedge i_clk);
  endtask
endmodule

// ---- test/wake_timer_regs_monitor.sv ----
// Checker for the wake pull, bus mode and cyclic timer register group.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
module wake_timer_regs_monitor (
  // Clock, reset and inputs
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic I_SOFT_RESET,
  input wire logic I_SERIAL_CHIP_SELECT_LOW,
  input wire logic I_AUX_PIN_IS_WAKE,
  input wire logic I_CYCLIC_SENSE_SELECT,
  input wire logic I_TIMER_WAKE_SOURCE_ENABLE,
  // Observed outputs
  input wire logic O_WAKE_PIN_PULL_UP,
  input wire logic O_WAKE_PIN_PULL_DOWN,
  input wire logic O_WAKE_PIN_PULL_AUTO,
  input wire logic O_AUX_PIN_PULL_UP,
  input wire logic O_AUX_PIN_PULL_DOWN,
  input wire logic O_AUX_PIN_PULL_AUTO,
  input wire logic O_SLEW_CONTROL_ENABLE,
  input wire logic O_CYCLIC_SENSE_ACTIVE,
  input wire logic O_CYCLIC_WAKE_EVENT
);
  // Single domain
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);

  // Pull selections are exclusive codes
  AST_WAKE_PULL_ONEHOT: assert property (
    $onehot0({O_WAKE_PIN_PULL_UP, O_WAKE_PIN_PULL_DOWN, O_WAKE_PIN_PULL_AUTO}))
    else $error("wake pin pulls not exclusive");
  AST_AUX_PULL_ONEHOT: assert property (
    $onehot0({O_AUX_PIN_PULL_UP, O_AUX_PIN_PULL_DOWN, O_AUX_PIN_PULL_AUTO}))
    else $error("aux pin pulls not exclusive");
  AST_AUX_PULL_GATED: assert property (
    !I_AUX_PIN_IS_WAKE [*3] |-> !(O_AUX_PIN_PULL_UP || O_AUX_PIN_PULL_DOWN
                                  || O_AUX_PIN_PULL_AUTO))
    else $error("aux pull active while pin not a wake input");
  // Timer results follow their enables
  AST_WAKE_NEEDS_ENABLE: assert property (
    O_CYCLIC_WAKE_EVENT |-> $past(I_TIMER_WAKE_SOURCE_ENABLE))
    else $error("timer wake without wake enable");
  AST_WAKE_ONE_CYCLE: assert property (
    O_CYCLIC_WAKE_EVENT |=> !O_CYCLIC_WAKE_EVENT)
    else $error("timer wake pulse longer than one cycle");
  AST_SENSE_NEEDS_SELECT: assert property (
    O_CYCLIC_SENSE_ACTIVE |-> $past(I_CYCLIC_SENSE_SELECT))
    else $error("cyclic sense active without selection");
  // Soft reset returns outputs to reset levels
  AST_SOFT_RESET_CLEARS: assert property (
    I_SOFT_RESET [*3] |=> O_SLEW_CONTROL_ENABLE && !O_WAKE_PIN_PULL_UP
      && !O_WAKE_PIN_PULL_DOWN && !O_WAKE_PIN_PULL_AUTO)
    else $error("soft reset left settings active");
  // Slew setting moves only after select release or soft reset
  AST_SLEW_AT_RELEASE: assert property (
    $changed(O_SLEW_CONTROL_ENABLE) |-> $past(I_SERIAL_CHIP_SELECT_LOW)
      || $past(I_SOFT_RESET))
    else $error("slew setting changed inside a frame");
endmodule

// ---- test/wake_timer_regs_tb_top.sv ----
// Self-checking bench for the wake pull, bus mode and cyclic timer registers.
// Assumes host model and checker compiled first; inputs move on falling edges.
`timescale 1ns/1ps
module wake_timer_regs_tb_top;
  import wake_timer_regs_pkg::*;
  localparam int TICK = 4; // Short tick keeps timer periods to a few thousand cycles

  // Design connections, named as the design ports
  logic I_CLK_SYS, I_SYS_RST, I_SOFT_RESET, I_SERIAL_CHIP_SELECT_LOW, I_SERIAL_CLOCK;
  logic I_SERIAL_DATA_IN, O_SERIAL_DATA_OUT, O_SERIAL_DATA_OUT_OE, I_RESTART_MODE;
  logic I_AUX_PIN_IS_WAKE, I_CYCLIC_SENSE_SELECT, I_HS_SWITCH_CLEAR, I_TIMER_ASSIGNED;
  logic I_TIMER_WAKE_SOURCE_ENABLE, O_WAKE_PIN_PULL_UP, O_WAKE_PIN_PULL_DOWN;
  logic O_WAKE_PIN_PULL_AUTO, O_AUX_PIN_PULL_UP, O_AUX_PIN_PULL_DOWN, O_AUX_PIN_PULL_AUTO;
  logic O_SLEW_CONTROL_ENABLE, O_HIGH_SIDE_SWITCH_OUTPUT, O_CYCLIC_SENSE_ACTIVE;
  logic O_CYCLIC_WAKE_EVENT;
  // Bench state
  int         n_mismatch = 0;
  int         checks     = 0;
  int         n_wake     = 0;
  logic [7:0] rd;
  logic [7:0] pull_tab [4] = '{8'h00, 8'h02, 8'h04, 8'h01};

  wake_timer_regs #(.TICK_CYCLES_P(TICK)) i_dut (.I_CLK_SYS, .I_SYS_RST, .I_SOFT_RESET,
    .I_SERIAL_CHIP_SELECT_LOW, .I_SERIAL_CLOCK, .I_SERIAL_DATA_IN, .O_SERIAL_DATA_OUT,
    .O_SERIAL_DATA_OUT_OE, .I_RESTART_MODE, .I_AUX_PIN_IS_WAKE, .I_CYCLIC_SENSE_SELECT,
    .I_HS_SWITCH_CLEAR, .I_TIMER_ASSIGNED, .I_TIMER_WAKE_SOURCE_ENABLE,
    .O_WAKE_PIN_PULL_UP, .O_WAKE_PIN_PULL_DOWN, .O_WAKE_PIN_PULL_AUTO, .O_AUX_PIN_PULL_UP,
    .O_AUX_PIN_PULL_DOWN, .O_AUX_PIN_PULL_AUTO, .O_SLEW_CONTROL_ENABLE,
    .O_HIGH_SIDE_SWITCH_OUTPUT, .O_CYCLIC_SENSE_ACTIVE, .O_CYCLIC_WAKE_EVENT);
  serial_host_model i_host (.i_clk(I_CLK_SYS), .o_cs_low(I_SERIAL_CHIP_SELECT_LOW),
    .o_sclk(I_SERIAL_CLOCK), .o_mosi(I_SERIAL_DATA_IN), .i_miso(O_SERIAL_DATA_OUT));

  // 50 MHz clock
  initial begin
    I_CLK_SYS = 1'b0;
    forever #10 I_CLK_SYS = ~I_CLK_SYS;
  end
  // Wake pulses are one cycle wide, so count them on every rising edge
  always @(posedge I_CLK_SYS) begin
    if (O_CYCLIC_WAKE_EVENT === 1'b1) n_wake++;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge I_CLK_SYS);
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_host.frame(a, 1'b1, d, 16, rd);
  endtask
  task automatic rdv(input logic [6:0] a, input logic [7:0] exp, input string what);
    i_host.frame(a, 1'b0, 8'h00, 16, rd);
    check(what, exp, rd);
  endtask

  task automatic test_reset;
    rdv(WAKE_PULL_CONFIG_ADDR, 8'h00, "pull reset");
    rdv(BUS_FAST_MODE_CONTROL_ADDR, 8'h00, "bus reset");
    rdv(CYCLIC_TIMER_CONTROL_ADDR, 8'h00, "timer reset");
    rdv(7'h09, 8'h00, "unmapped read");
    check("data out enable idle", 1'b0, O_SERIAL_DATA_OUT_OE);
    check("slew at reset", 1'b1, O_SLEW_CONTROL_ENABLE);
    $display("test reset done");
  endtask

  // Every pull code on both fields, aux gating toggled, reserved bits written as ones
  task automatic test_pulls;
    for (int v = 0; v < 4; v++) begin
      I_AUX_PIN_IS_WAKE = v[0];
      wr(WAKE_PULL_CONFIG_ADDR, {2'(3 - v), 4'hF, 2'(v)});
      cyc(4);
      rdv(WAKE_PULL_CONFIG_ADDR, {2'(3 - v), 4'h0, 2'(v)}, "pull readback");
      check("wake pulls", pull_tab[v], {O_WAKE_PIN_PULL_UP, O_WAKE_PIN_PULL_DOWN,
            O_WAKE_PIN_PULL_AUTO});
      check("aux pulls", v[0] ? pull_tab[3 - v] : 8'h00, {O_AUX_PIN_PULL_UP,
            O_AUX_PIN_PULL_DOWN, O_AUX_PIN_PULL_AUTO});
    end
    $display("test pulls done");
  endtask

  // Fast bit both ways, then a short frame that must be refused
  task automatic test_fast;
    logic [7:0] d [2] = '{8'hEF, 8'hFF};
    foreach (d[i]) begin
      wr(BUS_FAST_MODE_CONTROL_ADDR, d[i]);
      cyc(4);
      rdv(BUS_FAST_MODE_CONTROL_ADDR, d[i] & 8'h10, "bus readback");
      check("slew control", !d[i][4], O_SLEW_CONTROL_ENABLE);
    end
    i_host.frame(BUS_FAST_MODE_CONTROL_ADDR, 1'b1, 8'h00, 15, rd);
    cyc(4);
    check("short frame ignored", 1'b0, O_SLEW_CONTROL_ENABLE);
    $display("test fast done");
  endtask

  // Each running on-time code with rising period codes, measured at the output
  task automatic test_timer;
    int hi;
    int lo;
    int w0;
    I_TIMER_ASSIGNED = 1'b1;
    I_CYCLIC_SENSE_SELECT = 1'b1;
    I_TIMER_WAKE_SOURCE_ENABLE = 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(CYCLIC_TIMER_CONTROL_ADDR, {1'b1, 3'(i + 1), 4'(i)});
      hi = 0;
      lo = 0;
      while (O_HIGH_SIDE_SWITCH_OUTPUT !== 1'b1 && lo < 8) begin
        cyc(1);
        lo++;
      end
      check("on at release", 1'b1, O_HIGH_SIDE_SWITCH_OUTPUT);
      while (O_HIGH_SIDE_SWITCH_OUTPUT === 1'b1 && hi < 10000) begin
        cyc(1);
        hi++;
      end
      // Sense flag trails the first start by two registers, so look after the on-time
      check("sense running", 1'b1, O_CYCLIC_SENSE_ACTIVE);
      w0 = n_wake;
      lo = 0;
      while (O_HIGH_SIDE_SWITCH_OUTPUT === 1'b0 && lo < 10000) begin
        cyc(1);
        lo++;
      end
      cyc(2);
      check("on time", ON_TICKS[i + 1] * TICK, hi);
      check("period", PER_TICKS[i] * TICK, hi + lo);
      check("wake per period", 1, n_wake - w0);
    end
    rdv(CYCLIC_TIMER_CONTROL_ADDR, 8'h54, "timer readback");
    wr(CYCLIC_TIMER_CONTROL_ADDR, 8'h60);
    cyc(30);
    check("held high", 1'b1, O_HIGH_SIDE_SWITCH_OUTPUT);
    check("held not running", 1'b0, O_CYCLIC_SENSE_ACTIVE);
    wr(CYCLIC_TIMER_CONTROL_ADDR, 8'h00);
    cyc(30);
    check("stopped low", 1'b0, O_HIGH_SIDE_SWITCH_OUTPUT);
    $display("test timer done");
  endtask

  // Restart keeps pulls, fast bit and timer; clearing the sense switch wipes only the timer
  task automatic test_restart;
    int w0;
    wr(WAKE_PULL_CONFIG_ADDR, 8'h81);
    wr(CYCLIC_TIMER_CONTROL_ADDR, 8'h10);
    I_TIMER_WAKE_SOURCE_ENABLE = 1'b0;
    w0 = n_wake;
    cyc(900);
    check("no wake when disabled", w0, n_wake);
    I_RESTART_MODE = 1'b1;
    cyc(4);
    rdv(WAKE_PULL_CONFIG_ADDR, 8'h81, "pull kept");
    rdv(BUS_FAST_MODE_CONTROL_ADDR, 8'h10, "fast kept");
    rdv(CYCLIC_TIMER_CONTROL_ADDR, 8'h10, "timer kept");
    I_HS_SWITCH_CLEAR = 1'b1;
    cyc(4);
    I_HS_SWITCH_CLEAR = 1'b0;
    rdv(CYCLIC_TIMER_CONTROL_ADDR, 8'h00, "timer cleared");
    rdv(WAKE_PULL_CONFIG_ADDR, 8'h81, "pull after clear");
    I_RESTART_MODE = 1'b0;
    $display("test restart done");
  endtask

  task automatic test_soft;
    I_SOFT_RESET = 1'b1;
    cyc(4);
    I_SOFT_RESET = 1'b0;
    rdv(WAKE_PULL_CONFIG_ADDR, 8'h00, "pull soft");
    rdv(BUS_FAST_MODE_CONTROL_ADDR, 8'h00, "bus soft");
    check("slew soft", 1'b1, O_SLEW_CONTROL_ENABLE);
    $display("test soft done");
  endtask

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected 21k cycles
  initial begin
    cyc(80000);
    n_mismatch++;
    $display("MISMATCH watchdog expected done seen hang");
    complete_run();
  end

  // Main sequence
  initial begin
    I_SYS_RST = 1'b1;
    {I_SOFT_RESET, I_RESTART_MODE, I_AUX_PIN_IS_WAKE, I_CYCLIC_SENSE_SELECT} = 4'h0;
    {I_HS_SWITCH_CLEAR, I_TIMER_ASSIGNED, I_TIMER_WAKE_SOURCE_ENABLE} = 3'h0;
    cyc(16);
    I_SYS_RST = 1'b0;
    test_reset();
    test_pulls();
    test_fast();
    test_timer();
    test_restart();
    test_soft();
    complete_run();
  end
endmodule

bind wake_timer_regs wake_timer_regs_monitor i_mon (.I_CLK_SYS, .I_SYS_RST, .I_SOFT_RESET,
  .I_SERIAL_CHIP_SELECT_LOW, .I_AUX_PIN_IS_WAKE, .I_CYCLIC_SENSE_SELECT,
  .I_TIMER_WAKE_SOURCE_ENABLE, .O_WAKE_PIN_PULL_UP, .O_WAKE_PIN_PULL_DOWN,
  .O_WAKE_PIN_PULL_AUTO, .O_AUX_PIN_PULL_UP, .O_AUX_PIN_PULL_DOWN, .O_AUX_PIN_PULL_AUTO,
  .O_SLEW_CONTROL_ENABLE, .O_CYCLIC_SENSE_ACTIVE, .O_CYCLIC_WAKE_EVENT);
